// ---- dv/eepec_host.sv ----
// Bus master model issuing control and array writes over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module eepec_host (
    // Clock
    input  wire logic        core_clk,
    // Avalon-MM master side
    output logic      [11:0] avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [3:0]  avs_byteenable,
    output logic      [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 12'h000;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_byteenable = 4'h1;
        avs_writedata  = 32'h00000000;
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write     <= 1'b0;
        avs_writedata <= ~{24'h000000, d};
    endtask

    // Read held until accepted, data taken at that edge
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read    <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/eepec_top_test.sv ----
// Self-checking bench for the EEPROM program/erase controller
`timescale 1ns/1ps
`default_nettype none
module eepec_top_test;
    typedef struct packed {
        logic [7:0] m;
        logic [8:0] i;
        logic [7:0] d;
        logic [8:0] c;
        logic [7:0] e;
    } eepec_row_t;

    localparam logic [11:0] CTRL = eepec_pkg::ADDR_CTRL;
    localparam logic [11:0] CFG  = eepec_pkg::ADDR_CFG;
    localparam logic [11:0] STAT = eepec_pkg::ADDR_STAT;
    localparam eepec_row_t ROWS [14] = '{
        '{8'h00, 9'h005, 8'h5a, 9'h005, 8'h5a}, '{8'h00, 9'h005, 8'h0f, 9'h005, 8'h0a},
        '{8'h00, 9'h006, 8'h33, 9'h006, 8'h33}, '{8'h14, 9'h006, 8'h00, 9'h005, 8'h0a},
        '{8'h00, 9'h015, 8'h11, 9'h015, 8'h11}, '{8'h0c, 9'h005, 8'h00, 9'h005, 8'hff},
        '{8'h00, 9'h006, 8'h44, 9'h006, 8'h44}, '{8'h18, 9'h006, 8'h0f, 9'h006, 8'h04},
        '{8'h1c, 9'h006, 8'h00, 9'h006, 8'hff}, '{8'h00, 9'h1ff, 8'h7e, 9'h1ff, 8'h7e},
        '{8'h04, 9'h12c, 8'h00, 9'h015, 8'hff}, '{8'h80, 9'h011, 8'hf0, 9'h032, 8'hf0},
        '{8'h40, 9'h000, 8'h0f, 9'h020, 8'h0f}, '{8'h00, 9'h110, 8'hff, 9'h110, 8'hff}};

    logic        core_clk;
    logic        reset_n;
    logic        special_test_mode;
    logic        special_boot_mode;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        programming_voltage;
    int          err_total;
    int          n_compared;

    eepec_top eepec_top_inst (
        .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .special_test_mode(special_test_mode), .special_boot_mode(special_boot_mode),
        .programming_voltage(programming_voltage)
    );

    eepec_host eepec_host_inst (
        .core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    always #4 core_clk = ~core_clk;

    function automatic logic [11:0] arr(input logic [8:0] i);
        return {1'b1, i, 2'b00};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_rd(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        eepec_host_inst.rd(a, q);
        check(name, q, exp);
    endtask

    task automatic chk_pv(input logic exp);
        @(negedge core_clk);
        check("supply", {31'h0, programming_voltage}, {31'h0, exp});
    endtask

    // latch, address, supply on, then clear
    task automatic op(input logic [7:0] m, input logic [11:0] a, input logic [7:0] d);
        eepec_host_inst.wr(CTRL, m | 8'h02);
        eepec_host_inst.wr(a, d);
        eepec_host_inst.wr(CTRL, m | 8'h03);
        chk_pv(1'b1);
        eepec_host_inst.wr(CTRL, 8'h00);
        chk_pv(1'b0);
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        stop_test;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        core_clk          = 1'b0;
        reset_n           = 1'b0;
        special_test_mode = 1'b0;
        special_boot_mode = 1'b0;
        err_total         = 0;
        n_compared        = 0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk_pv(1'b0);
        chk_rd("ctrl", CTRL, 32'h0);
        chk_rd("cfg", CFG, 32'hff);
        chk_rd("top byte", arr(9'h1ff), 32'hff);
        chk_rd("unmapped", 12'h00c, 32'h0);
        foreach (ROWS[k]) begin
            op(ROWS[k].m, arr(ROWS[k].i), ROWS[k].d);
            chk_rd("row op", arr(ROWS[k].c), {24'h0, ROWS[k].e});
        end
        eepec_host_inst.wr(CTRL, 8'h03);
        chk_rd("both bits", CTRL, 32'h0);
        chk_pv(1'b0);
        eepec_host_inst.wr(CTRL, 8'h02);
        eepec_host_inst.wr(arr(9'h032), 8'h00);
        eepec_host_inst.wr(CTRL, 8'h00);
        eepec_host_inst.wr(CTRL, 8'h02);
        eepec_host_inst.wr(CTRL, 8'h03);
        eepec_host_inst.wr(CTRL, 8'h00);
        chk_rd("no address", arr(9'h032), 32'hf0);
        eepec_host_inst.wr(CTRL, 8'h02);
        eepec_host_inst.wr(arr(9'h007), 8'h00);
        chk_rd("hidden", arr(9'h007), {24'h0, eepec_pkg::ARRAY_HIDDEN});
        chk_rd("armed", STAT, 32'h1 << eepec_pkg::STAT_ARMED);
        eepec_host_inst.wr(CTRL, 8'h03);
        eepec_host_inst.wr(arr(9'h008), 8'h00);
        chk_rd("status hv", STAT, 32'h1 << eepec_pkg::STAT_HV);
        eepec_host_inst.wr(CTRL, 8'h00);
        chk_rd("captured", arr(9'h007), 32'h0);
        chk_rd("inhibited", arr(9'h008), 32'h0f);
        eepec_host_inst.wr(CTRL, 8'h02);
        eepec_host_inst.wr(arr(9'h100), 8'ha5);
        eepec_host_inst.wr(CTRL, 8'h03);
        eepec_host_inst.wr(CTRL, 8'h02);
        eepec_host_inst.wr(arr(9'h101), 8'h5a);
        eepec_host_inst.wr(CTRL, 8'h03);
        eepec_host_inst.wr(CTRL, 8'h00);
        chk_rd("multi a", arr(9'h100), 32'ha5);
        chk_rd("multi b", arr(9'h101), 32'h5a);
        op(8'h00, CFG, 8'h00);
        chk_rd("cfg locked", CFG, 32'hff);
        special_test_mode <= 1'b1;
        repeat (4) @(posedge core_clk);
        op(8'h00, CFG, 8'h3c);
        chk_rd("cfg test", CFG, 32'h3c);
        special_test_mode <= 1'b0;
        special_boot_mode <= 1'b1;
        repeat (4) @(posedge core_clk);
        op(8'h14, CFG, 8'h00);
        chk_rd("cfg byte erase", CFG, 32'h3c);
        op(8'h04, CFG, 8'h00);
        chk_rd("cfg boot", CFG, 32'hff);
        chk_rd("array kept", arr(9'h100), 32'ha5);
        special_boot_mode <= 1'b0;
        eepec_host_inst.wr(CTRL, 8'h02);
        eepec_host_inst.wr(CTRL, 8'h03);
        chk_pv(1'b1);
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk_pv(1'b0);
        @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk_rd("ctrl after reset", CTRL, 32'h0);
        chk_rd("stat after reset", STAT, 32'h0);
        stop_test;
    end
endmodule
`default_nettype wire

// ---- rtl/eepec_pkg.sv ----
// Package with map, field positions and types for the EEPROM program/erase controller
package eepec_pkg;

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam int unsigned ARRAY_BYTES   = 512;
    localparam int unsigned ROW_COUNT     = 32;
    localparam int unsigned ROW_BYTES     = 16;
    localparam int unsigned IDX_W         = 9;
    localparam int unsigned ROW_LSB       = 4;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W        = 12;
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_CFG      = 12'h004;
    localparam logic [11:0] ADDR_STAT     = 12'h008;
    localparam int unsigned ARRAY_SEL_BIT = 11;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_ODD      = 7;
    localparam int unsigned CTRL_EVEN     = 6;
    localparam int unsigned CTRL_BYTE     = 4;
    localparam int unsigned CTRL_ROW      = 3;
    localparam int unsigned CTRL_ERASE    = 2;
    localparam int unsigned CTRL_LATCH    = 1;
    localparam int unsigned CTRL_HV       = 0;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int unsigned STAT_ARMED    = 0;
    localparam int unsigned STAT_SPECIAL  = 1;
    localparam int unsigned STAT_HV       = 2;

    // ------------------------------------------------------------------
    // Reset and data values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam logic [7:0]  CFG_RESET     = 8'hff;
    localparam logic [7:0]  ARRAY_HIDDEN  = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic odd;
        logic even;
        logic byte_sel;
        logic row_sel;
        logic erase;
        logic latch;
        logic hv;
    } eepec_ctrl_t;

    typedef struct packed {
        logic             valid;
        logic             is_cfg;
        logic [IDX_W-1:0] idx;
        logic [7:0]       data;
    } eepec_cap_t;

endpackage

// ---- rtl/eepec_top.sv ----
// EEPROM program/erase sequencer with Avalon-MM register access
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Array is a fixed 512-byte window of 32 rows of 16 bytes.
// - Row index comes from address bits 10 to 6, the array index bits above the low four.
// - Byte, row and bulk erase; config byte is separate with own restrictions.
// - Erase leaves every bit of each targeted byte at one.
// - Programming only clears bits written as zero.
// - Config byte changes only in special test or bootstrap mode.
// - Latch first, then address write, then latch plus high voltage.
// - Writing latch and high voltage to one together while latch is clear sets neither.
// - Array writes are ignored while high voltage is on.
// - No array write since latch set means no array change.
// - Odd or even bit programs all such rows in one array half.
// - Byte and row select are ignored when erase is clear.
// - Byte select erases byte; else row select erases row; else bulk.
// - Erase bit clear means read or program, set means erase.
// - Latch set hides array from reads and captures array writes.
// - High-voltage bit switches the programming supply.
// - Latch may stay set across several program cycles.
module eepec_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Mode pins
    input  wire logic        special_test_mode,
    input  wire logic        special_boot_mode,
    // Array supply
    output logic             programming_voltage
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        eepec_pkg::eepec_ctrl_t                ctrl;
        eepec_pkg::eepec_cap_t                 cap;
        logic [7:0]                            cfg;
        logic [eepec_pkg::ARRAY_BYTES-1:0][7:0] mem;
        logic [1:0]                            mode_meta;
        logic [1:0]                            mode_sync;
        logic                                  wait_r;
        logic [31:0]                           rdata;
        logic                                  hv_out;
    } eepec_state_t;

    eepec_state_t s_q;
    eepec_state_t s_d;
    logic         rst_meta_q;
    logic         rst_sync_q;

    logic         req;
    logic         wr_acc;
    logic         rd_start;
    logic         is_ctrl;
    logic         is_cfg;
    logic         is_stat;
    logic         is_arr;
    logic         special;
    logic         both_set;
    logic         fire;
    logic [eepec_pkg::IDX_W-1:0] addr_idx;
    logic [7:0]   wc;
    eepec_pkg::eepec_ctrl_t ctrl_n;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign req      = avs_read | avs_write;
    assign wr_acc   = avs_write & ~s_q.wait_r;
    assign rd_start = avs_read & s_q.wait_r;
    assign is_ctrl  = (avs_address == eepec_pkg::ADDR_CTRL);
    assign is_cfg   = (avs_address == eepec_pkg::ADDR_CFG);
    assign is_stat  = (avs_address == eepec_pkg::ADDR_STAT);
    assign is_arr   = avs_address[eepec_pkg::ARRAY_SEL_BIT] & (avs_address[1:0] == 2'b00);
    assign addr_idx = avs_address[eepec_pkg::IDX_W+1:2];
    assign special  = |s_q.mode_sync;
    assign wc       = avs_writedata[7:0];

    assign both_set = ~s_q.ctrl.latch & ~s_q.ctrl.hv & wc[eepec_pkg::CTRL_LATCH] & wc[eepec_pkg::CTRL_HV];

    always_comb begin
        ctrl_n = s_q.ctrl;
        if (wr_acc && is_ctrl && avs_byteenable[0]) begin
            ctrl_n.odd      = wc[eepec_pkg::CTRL_ODD];
            ctrl_n.even     = wc[eepec_pkg::CTRL_EVEN];
            ctrl_n.byte_sel = wc[eepec_pkg::CTRL_BYTE];
            ctrl_n.row_sel  = wc[eepec_pkg::CTRL_ROW];
            ctrl_n.erase    = wc[eepec_pkg::CTRL_ERASE];
            ctrl_n.latch    = wc[eepec_pkg::CTRL_LATCH] & ~both_set;
            ctrl_n.hv       = wc[eepec_pkg::CTRL_HV] & wc[eepec_pkg::CTRL_LATCH] & s_q.ctrl.latch;
        end
    end

    // fire only with a captured address
    assign fire = ~s_q.ctrl.hv & ctrl_n.hv & s_q.cap.valid;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.mode_meta = {special_test_mode, special_boot_mode};
        s_d.mode_sync = s_q.mode_meta;
        s_d.wait_r    = ~(req & s_q.wait_r);
        s_d.ctrl      = ctrl_n;
        s_d.hv_out    = ctrl_n.hv;

        // Read data
        if (rd_start) begin
            s_d.rdata = 32'h0000_0000;
            if (is_ctrl) begin
                s_d.rdata[7:0] = {s_q.ctrl.odd, s_q.ctrl.even, 1'b0, s_q.ctrl.byte_sel,
                                  s_q.ctrl.row_sel, s_q.ctrl.erase, s_q.ctrl.latch, s_q.ctrl.hv};
            end else if (is_stat) begin
                s_d.rdata[eepec_pkg::STAT_ARMED]   = s_q.cap.valid;
                s_d.rdata[eepec_pkg::STAT_SPECIAL] = special;
                s_d.rdata[eepec_pkg::STAT_HV]      = s_q.hv_out;
            end else if (is_cfg) begin
                s_d.rdata[7:0] = s_q.ctrl.latch ? eepec_pkg::ARRAY_HIDDEN : s_q.cfg;
            end else if (is_arr) begin
                s_d.rdata[7:0] = s_q.ctrl.latch ? eepec_pkg::ARRAY_HIDDEN : s_q.mem[addr_idx];
            end
        end

        if (~s_q.ctrl.latch & ctrl_n.latch) begin
            s_d.cap.valid = 1'b0;
        end

        // capture only while latched and supply off
        if (wr_acc && avs_byteenable[0] && (is_arr || is_cfg) && s_q.ctrl.latch && !s_q.ctrl.hv) begin
            s_d.cap.valid  = 1'b1;
            s_d.cap.is_cfg = is_cfg;
            s_d.cap.idx    = is_cfg ? '0 : addr_idx;
            s_d.cap.data   = wc;
        end

        // Apply operation; capture consumed, latch kept
        if (fire) begin
            s_d.cap.valid = 1'b0;
            if (s_q.cap.is_cfg) begin
                // config needs special mode, erase only as bulk
                if (special) begin
                    if (ctrl_n.erase) begin
                        if (!ctrl_n.byte_sel && !ctrl_n.row_sel) begin
                            s_d.cfg = eepec_pkg::ERASED_BYTE;
                        end
                    end else begin
                        s_d.cfg = s_q.cfg & s_q.cap.data;
                    end
                end
            end else if (ctrl_n.erase) begin
                for (int i = 0; i < eepec_pkg::ARRAY_BYTES; i++) begin
                    if (ctrl_n.byte_sel) begin
                        if (i[8:0] == s_q.cap.idx) begin
                            s_d.mem[i] = eepec_pkg::ERASED_BYTE;
                        end
                    end else if (ctrl_n.row_sel) begin
                        if (i[8:4] == s_q.cap.idx[8:4]) begin
                            s_d.mem[i] = eepec_pkg::ERASED_BYTE;
                        end
                    end else begin
                        s_d.mem[i] = eepec_pkg::ERASED_BYTE;
                    end
                end
            end else if (ctrl_n.odd || ctrl_n.even) begin
                // odd or even rows in one half
                for (int i = 0; i < eepec_pkg::ARRAY_BYTES; i++) begin
                    if ((i[8] == s_q.cap.idx[8]) && ((ctrl_n.odd && i[4]) || (ctrl_n.even && !i[4]))) begin
                        s_d.mem[i] = s_q.mem[i] & s_q.cap.data;
                    end
                end
            end else begin
                s_d.mem[s_q.cap.idx] = s_q.mem[s_q.cap.idx] & s_q.cap.data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_q        <= '0;
            s_q.mem    <= '1;
            s_q.cfg    <= eepec_pkg::CFG_RESET;
            s_q.wait_r <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata        = s_q.rdata;
    assign avs_waitrequest     = s_q.wait_r;
    assign programming_voltage = s_q.hv_out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_q);

    property p_both_refused;
        wr_acc && is_ctrl && avs_byteenable[0] && both_set |=> !s_q.ctrl.latch && !s_q.ctrl.hv;
    endproperty
    a_both_refused: assert property (p_both_refused) else $error("latch and hv set together");

    property p_hv_after_latch;
        $rose(programming_voltage) |-> $past(s_q.ctrl.latch, 2);
    endproperty
    a_hv_after_latch: assert property (p_hv_after_latch) else $error("supply on without prior latch");

    property p_no_capture_hv;
        s_q.ctrl.hv && wr_acc && is_arr |=> s_q.cap == $past(s_q.cap);
    endproperty
    a_no_capture_hv: assert property (p_no_capture_hv) else $error("capture changed under hv");

    property p_no_addr_no_change;
        s_q.ctrl.hv && !$past(s_q.ctrl.hv) && !$past(s_q.cap.valid) |-> s_q.mem == $past(s_q.mem);
    endproperty
    a_no_addr_no_change: assert property (p_no_addr_no_change) else $error("array changed without address");

    property p_byte_erase;
        fire && ctrl_n.erase && ctrl_n.byte_sel && !s_q.cap.is_cfg |=> s_q.mem[$past(s_q.cap.idx)] == 8'hff;
    endproperty
    a_byte_erase: assert property (p_byte_erase) else $error("byte not erased");

    property p_bulk_erase;
        fire && ctrl_n.erase && !ctrl_n.byte_sel && !ctrl_n.row_sel && !s_q.cap.is_cfg |=> &s_q.mem;
    endproperty
    a_bulk_erase: assert property (p_bulk_erase) else $error("bulk erase incomplete");

    property p_program;
        fire && !ctrl_n.erase && !ctrl_n.odd && !ctrl_n.even && !s_q.cap.is_cfg
            |=> s_q.mem[$past(s_q.cap.idx)] == ($past(s_q.mem[s_q.cap.idx]) & $past(s_q.cap.data));
    endproperty
    a_program: assert property (p_program) else $error("program result wrong");

    property p_cfg_guard;
        s_q.cfg != $past(s_q.cfg) |-> $past(special);
    endproperty
    a_cfg_guard: assert property (p_cfg_guard) else $error("config changed outside special mode");

    property p_hidden_read;
        rd_start && is_arr && s_q.ctrl.latch |=> !avs_waitrequest && avs_readdata == 32'h0;
    endproperty
    a_hidden_read: assert property (p_hidden_read) else $error("array visible while latched");

    property p_supply_needs_latch;
        programming_voltage |-> s_q.ctrl.latch;
    endproperty
    a_supply_needs_latch: assert property (p_supply_needs_latch) else $error("supply on with latch clear");

    property p_row_erase;
        fire && ctrl_n.erase && !ctrl_n.byte_sel && ctrl_n.row_sel && !s_q.cap.is_cfg
            |=> s_q.mem[{$past(s_q.cap.idx[8:4]), 4'hf}] == eepec_pkg::ERASED_BYTE;
    endproperty
    a_row_erase: assert property (p_row_erase) else $error("row end not erased");

    property p_capture;
        wr_acc && avs_byteenable[0] && is_arr && s_q.ctrl.latch && !s_q.ctrl.hv
            |=> s_q.cap.valid && s_q.cap.idx == $past(addr_idx);
    endproperty
    a_capture: assert property (p_capture) else $error("array write not captured");

    property p_cfg_bulk_only;
        fire && s_q.cap.is_cfg && ctrl_n.erase && (ctrl_n.byte_sel || ctrl_n.row_sel)
            |=> s_q.cfg == $past(s_q.cfg);
    endproperty
    a_cfg_bulk_only: assert property (p_cfg_bulk_only) else $error("config erased by byte or row");

    c_program:  cover property (fire && !ctrl_n.erase);
    c_bulk:     cover property (fire && ctrl_n.erase && !ctrl_n.byte_sel && !ctrl_n.row_sel);
    c_row:      cover property (fire && ctrl_n.erase && !ctrl_n.byte_sel && ctrl_n.row_sel);
    c_refused:  cover property (wr_acc && is_ctrl && both_set);
    c_odd_even: cover property (fire && (ctrl_n.odd || ctrl_n.even));

endmodule

`default_nettype wire
